// *** core_model.sv ***
// partner model of the core: takes presented vectors, issues returns
module core_model
(
    // clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    rst_n_i,
    // steering from the bench
    input  wire logic                    arm_i,
    input  wire logic [3:0]              wait_i,
    input  wire logic                    ret_i,
    input  wire logic                    ie_i,
    // controller side
    input  wire irq_prio_pkg::core_out_t pres_i,
    output irq_prio_pkg::core_in_t       ind_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import irq_prio_pkg::*;

    logic [3:0] wait_ff; // cycles spent looking at the presented vector
    logic       ack_ff;  // acknowledge pulse
    logic       interrupt_return_instruction_ff; // return pulse

    // acknowledge a presented vector after the chosen delay, once only
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wait_ff <= 4'h0;
            ack_ff  <= 1'b0;
        end
        else if (ack_ff || !(arm_i && pres_i.valid))
        begin
            wait_ff <= 4'h0;
            ack_ff  <= 1'b0;
        end
        else if (wait_ff == wait_i)
            ack_ff <= 1'b1;
        else
            wait_ff <= wait_ff + 4'h1;
    end

    // return pulse is the bench's ret_i request, registered one cycle later
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            interrupt_return_instruction_ff <= 1'b0;
        else
            interrupt_return_instruction_ff <= ret_i;
    end

    assign ind_o = {ack_ff, interrupt_return_instruction_ff, ie_i};
endmodule

// *** cpu_irq_controller.sv ***
// priority interrupt controller between peripheral requests and the core
// Notes on behaviour
// - level flags restore previous level on return
// - protected write needs key, within four instructions
// - unlocked-less protected write changes nothing
// - placement and compact bits need unlock key
// - round robin bit always writable
// - placement bit picks boot start or after
// - placement ignored when all memory is boot
// - compact bit turns compact table on
// - fixed priority or round robin for level 0
// - nmi flag set in handler, cleared on return
// - level 1 flag held through nmi preemption
// - level 0 flag held through any preemption
// - high vector field, zero disables level 1
// - level 0 pointer register, read/write, reset zero
// - pointer vector lowest, next one highest, wrapping
// - round robin loads pointer on level 0 ack
// - compact table uses vectors 1, 2, 3
// - nmi never preempted; level 1 preempts level 0
module cpu_irq_controller
(
    // clock, reset, enable
    input  wire logic                    clock_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    ce_i,
    // register port
    input  wire irq_prio_pkg::reg_req_t  req_i,
    output logic [7:0]                   rdata_o,
    // protection and memory layout
    input  wire logic                    ccp_key_i,
    input  wire logic                    instr_done_i,
    input  wire logic                    boot_all_i,
    output logic                         vec_boot_start_o,
    // requests and core handshake
    input  wire logic [31:0]             irq_req_i,
    input  wire irq_prio_pkg::core_in_t  core_i,
    output irq_prio_pkg::core_out_t      core_o
);
    import irq_prio_pkg::*;

    state_t     st_ff;     // registered state
    state_t     nxt_st;    // next state
    logic [31:0] lo_req;   // level 0 candidates
    logic [4:0] idx;       // scan index
    logic [4:0] win;       // level 0 winner
    logic       found;     // level 0 winner exists
    logic       hi_on;     // a level 1 vector is selected
    logic       hi_ok;     // level 1 may be presented
    logic       nmi_ok;    // nmi may be presented
    logic       lo_ok;     // level 0 may be presented
    logic       acked;     // presented request taken
    logic [7:0] rd_v;      // read mux value

    // outputs come straight from state flops
    assign rdata_o          = st_ff.rdata;
    assign vec_boot_start_o = st_ff.boot_start;
    assign core_o           = st_ff.out;
    assign acked            = core_i.ack && st_ff.out.valid;

    // next state
    always_comb
    begin
        nxt_st = st_ff;
        rd_v   = RST_REG;
        lo_req = irq_req_i;
        found  = 1'b0;
        win    = 5'h00;
        idx    = 5'h00;
        // unlock window: key opens, each instruction counts down
        if (ccp_key_i)
        begin
            nxt_st.unlock = UNLOCK_INSTR;
        end
        else if (instr_done_i && st_ff.unlock != 3'h0)
        begin
            nxt_st.unlock = st_ff.unlock - 3'h1;
        end
        // register writes
        if (req_i.wr)
        begin
            case (req_i.addr)
                OFS_CTRL:
                begin
                    nxt_st.rr = req_i.wdata[BIT_RR];
                    if (st_ff.unlock != 3'h0)
                    begin
                        // protected bits, window then closes
                        nxt_st.place  = req_i.wdata[BIT_PLACE];
                        nxt_st.compact_table_enable    = req_i.wdata[BIT_CVT];
                        // a key in the same cycle reopens the window
                        if (!ccp_key_i)
                            nxt_st.unlock = 3'h0;
                    end
                    // without unlock the protected bits keep
                end
                OFS_PTR:  nxt_st.ptr  = req_i.wdata;
                OFS_HVEC: nxt_st.hvec = req_i.wdata;
                default:  ;                           // state and unmapped
            endcase
        end
        // read mux, unmapped reads zero
        case (req_i.addr)
            OFS_CTRL:
            begin
                rd_v[BIT_PLACE] = st_ff.place;
                rd_v[BIT_CVT]   = st_ff.compact_table_enable;
                rd_v[BIT_RR]    = st_ff.rr;
            end
            OFS_STAT:
            begin
                rd_v[BIT_NMI_EX] = st_ff.nmi_ex;
                rd_v[BIT_HI_EX]  = st_ff.hi_ex;
                rd_v[BIT_LO_EX]  = st_ff.lo_ex;
            end
            OFS_PTR:  rd_v = st_ff.ptr;
            OFS_HVEC: rd_v = st_ff.hvec;
            default:  rd_v = RST_REG;
        endcase
        nxt_st.rdata = req_i.rd ? rd_v : RST_REG;
        // return clears the highest active level only
        if (core_i.interrupt_return_instruction)
        begin
            if (st_ff.nmi_ex)
                nxt_st.nmi_ex = 1'b0;
            else if (st_ff.hi_ex)
                nxt_st.hi_ex = 1'b0;
            else
                nxt_st.lo_ex = 1'b0;
        end
        // acknowledge enters the presented level
        if (acked)
        begin
            case (st_ff.out.level)
                LVL_NMI: nxt_st.nmi_ex = 1'b1;
                LVL_HI:  nxt_st.hi_ex  = 1'b1;
                LVL_LO:
                begin
                    nxt_st.lo_ex = 1'b1;
                    if (st_ff.rr)
                        nxt_st.ptr = st_ff.raw;
                end
                default: ;
            endcase
        end
        // level 0 candidates exclude reset, nmi and the level 1 vector
        hi_on = st_ff.hvec != 8'h00 && st_ff.hvec < 8'(NVEC);
        lo_req[0] = 1'b0;
        lo_req[VEC_NMI[4:0]] = 1'b0;
        if (hi_on)
            lo_req[st_ff.hvec[4:0]] = 1'b0;
        // scan from pointer plus one, wrapping
        for (int k = 1; k <= NVEC; k++)
        begin
            idx = st_ff.ptr[4:0] + 5'(k);
            if (!found && lo_req[idx])
            begin
                found = 1'b1;
                win   = idx;
            end
        end
        // eligibility by executing level
        nmi_ok = irq_req_i[VEC_NMI[4:0]] && !st_ff.nmi_ex;
        hi_ok  = hi_on && irq_req_i[st_ff.hvec[4:0]] && core_i.ie
                 && !st_ff.nmi_ex && !st_ff.hi_ex;
        lo_ok  = found && core_i.ie && !st_ff.nmi_ex && !st_ff.hi_ex && !st_ff.lo_ex;
        // select and map vector, compact table remaps
        nxt_st.out.valid = 1'b1;
        if (nmi_ok)
        begin
            nxt_st.out.level  = LVL_NMI;
            nxt_st.raw        = VEC_NMI;
            nxt_st.out.vector = st_ff.compact_table_enable ? CVT_NMI : VEC_NMI;
        end
        else if (hi_ok)
        begin
            nxt_st.out.level  = LVL_HI;
            nxt_st.raw        = st_ff.hvec;
            nxt_st.out.vector = st_ff.compact_table_enable ? CVT_HI : st_ff.hvec;
        end
        else if (lo_ok)
        begin
            nxt_st.out.level  = LVL_LO;
            nxt_st.raw        = {3'h0, win};
            nxt_st.out.vector = st_ff.compact_table_enable ? CVT_LO : {3'h0, win};
        end
        else
        begin
            nxt_st.out = '0;
        end
        // hide the stale choice in the cycle after an acknowledge
        if (acked)
            nxt_st.out = '0;
        // table placement
        nxt_st.boot_start = st_ff.place && !boot_all_i;
    end

    // state register, frozen while ce_i is low
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_ff <= '0;
        else if (ce_i)
            st_ff <= nxt_st;
    end

    // checks
    property p_nmi_enter;
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && acked && st_ff.out.level == LVL_NMI |=> st_ff.nmi_ex;
    endproperty
    a_nmi_enter: assert property (p_nmi_enter)
        else $error("nmi flag not set on acknowledge");

    property p_nmi_leave;
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && st_ff.nmi_ex && core_i.interrupt_return_instruction && !acked |=> !st_ff.nmi_ex;
    endproperty
    a_nmi_leave: assert property (p_nmi_leave)
        else $error("nmi flag not cleared on return");

    property p_hi_hold;
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && st_ff.hi_ex && st_ff.nmi_ex && core_i.interrupt_return_instruction |=> st_ff.hi_ex;
    endproperty
    a_hi_hold: assert property (p_hi_hold)
        else $error("level 1 flag lost on nmi return");

    property p_lo_hold;
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && st_ff.lo_ex && (st_ff.hi_ex || st_ff.nmi_ex) && core_i.interrupt_return_instruction
        |=> st_ff.lo_ex;
    endproperty
    a_lo_hold: assert property (p_lo_hold)
        else $error("level 0 flag lost on higher return");

    property p_locked;
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && req_i.wr && req_i.addr == OFS_CTRL && st_ff.unlock == 3'h0
        |=> $stable(st_ff.place) && $stable(st_ff.compact_table_enable);
    endproperty
    a_locked: assert property (p_locked)
        else $error("protected bit changed without unlock");

    property p_rr_free;
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && req_i.wr && req_i.addr == OFS_CTRL |=> st_ff.rr == $past(req_i.wdata[BIT_RR]);
    endproperty
    a_rr_free: assert property (p_rr_free)
        else $error("round robin bit not written");

    property p_nmi_alone;
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && st_ff.nmi_ex |=> !st_ff.out.valid;
    endproperty
    a_nmi_alone: assert property (p_nmi_alone)
        else $error("request presented during nmi handler");

    property p_hi_off;
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && st_ff.hvec == 8'h00 |=> st_ff.out.level != LVL_HI;
    endproperty
    a_hi_off: assert property (p_hi_off)
        else $error("level 1 presented while disabled");

    property p_boot_all;
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && boot_all_i |=> !vec_boot_start_o;
    endproperty
    a_boot_all: assert property (p_boot_all)
        else $error("placement used with all-boot memory");

    property p_cvt_lo;
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && st_ff.compact_table_enable |=> st_ff.out.level != LVL_LO || st_ff.out.vector == CVT_LO;
    endproperty
    a_cvt_lo: assert property (p_cvt_lo)
        else $error("compact level 0 vector wrong");

    property p_rr_load;
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && acked && st_ff.rr && st_ff.out.level == LVL_LO |=> st_ff.ptr == $past(st_ff.raw);
    endproperty
    a_rr_load: assert property (p_rr_load)
        else $error("pointer not loaded on level 0 ack");

    property p_unlock_open;
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && ccp_key_i |=> st_ff.unlock == UNLOCK_INSTR;
    endproperty
    a_unlock_open: assert property (p_unlock_open)
        else $error("unlock window not opened by key");

    property p_place;
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && !boot_all_i |=> vec_boot_start_o == $past(st_ff.place);
    endproperty
    a_place: assert property (p_place)
        else $error("table placement does not follow placement bit");

    property p_lo_enter;
        @(posedge clock_i) disable iff (!rst_n_i)
        ce_i && acked && st_ff.out.level == LVL_LO |=> st_ff.lo_ex;
    endproperty
    a_lo_enter: assert property (p_lo_enter)
        else $error("level 0 flag not set on acknowledge");

endmodule

// *** cpu_irq_controller_tb.sv ***
// self-checking bench for the interrupt priority controller
module cpu_irq_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import irq_prio_pkg::*;

    logic        clock_i = 1'b0;  // 125 MHz clock
    logic        rst_n_i = 1'b0;  // active-low reset
    logic        key = 1'b0;      // unlock key pulse
    logic        done = 1'b0;     // instruction completed pulse
    logic        boot_all = 1'b0; // all memory is boot region
    logic        arm = 1'b0;      // core may take vectors
    logic        ret = 1'b0;      // ask core for a return
    logic [3:0]  dly = 4'h0;      // core acknowledge delay
    logic        ce = 1'b1;       // clock enable of the controller
    logic        ie = 1'b1;       // global interrupt enable of the core
    logic [31:0] irq = 32'h0;     // peripheral requests
    reg_req_t    req = '0;        // register port request
    logic [7:0]  rdata;           // register read data
    logic        boot_start;      // table placement
    core_in_t    ind;             // core indications
    core_out_t   pres;            // presented vector
    int          miscompares = 0;
    int          tests_run = 0;

    always #4 clock_i = ~clock_i;

    cpu_irq_controller dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce),
        .req_i(req), .rdata_o(rdata), .ccp_key_i(key), .instr_done_i(done),
        .boot_all_i(boot_all), .vec_boot_start_o(boot_start), .irq_req_i(irq),
        .core_i(ind), .core_o(pres));
    core_model core_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .arm_i(arm), .wait_i(dly),
        .ret_i(ret), .ie_i(ie), .pres_i(pres), .ind_o(ind));

    // print the verdict and stop
    task automatic give_verdict();
        if (miscompares == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // compare and report
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one write cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock_i);
        req.wr <= 1'b0;
    endtask

    // one read cycle, data judged in the cycle after
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock_i);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock_i);
        req.rd <= 1'b0;
        @(negedge clock_i);
        chk("rdata", e, rdata);
    endtask

    // unlock key, n instructions, then a control write
    task automatic prot(input int n, input logic [7:0] d);
        @(posedge clock_i);
        key <= 1'b1;
        @(posedge clock_i);
        key <= 1'b0;
        repeat (n)
        begin
            done <= 1'b1;
            @(posedge clock_i);
            done <= 1'b0;
            @(posedge clock_i);
        end
        wr(OFS_CTRL, d);
    endtask

    // wait for a presented vector and judge it
    task automatic pr(input logic [7:0] v, input lvl_t l);
        repeat (2) @(negedge clock_i);
        for (int i = 0; i < 20 && pres.valid !== 1'b1; i++) @(negedge clock_i);
        chk("valid", 8'h01, {7'h00, pres.valid});
        if (pres.valid !== 1'b1) give_verdict();
        chk("vector", v, pres.vector);
        chk("level", {6'h00, l}, {6'h00, pres.level});
    endtask

    // core takes the vector; requests then become nx
    task automatic take(input logic [3:0] d, input logic [31:0] nx);
        @(posedge clock_i);
        dly <= d;
        arm <= 1'b1;
        for (int i = 0; i < 20 && ind.ack !== 1'b1; i++) @(posedge clock_i);
        chk("ack", 8'h01, {7'h00, ind.ack});
        arm <= 1'b0;
        irq <= nx;
        if (ind.ack !== 1'b1) give_verdict();
    endtask

    // interrupt return
    task automatic iret();
        @(posedge clock_i);
        ret <= 1'b1;
        @(posedge clock_i);
        ret <= 1'b0;
    endtask

    // reset values, read-only state, unmapped offset
    task automatic s_regs();
        rd(OFS_CTRL, RST_REG);
        rd(OFS_PTR, RST_REG);
        rd(OFS_HVEC, RST_REG);
        wr(OFS_STAT, 8'hff);
        rd(OFS_STAT, RST_REG);
        wr(OFS_PTR, 8'ha5);
        rd(OFS_PTR, 8'ha5);
        // a write while the clock enable is low must be lost
        @(posedge clock_i);
        ce <= 1'b0;
        wr(OFS_PTR, 8'h5a);
        ce <= 1'b1;
        rd(OFS_PTR, 8'ha5);
        rd(8'h07, 8'h00);
        wr(OFS_PTR, 8'h00);
    endtask

    // protection window and table placement
    task automatic s_prot();
        wr(OFS_CTRL, 8'h61);
        rd(OFS_CTRL, 8'h01);
        prot(4, 8'h61);
        rd(OFS_CTRL, 8'h01);
        prot(3, 8'h60);
        rd(OFS_CTRL, 8'h60);
        chk("boot_start", 8'h01, {7'h00, boot_start});
        wr(OFS_CTRL, 8'h01);
        rd(OFS_CTRL, 8'h61);
        prot(0, 8'h00);
        rd(OFS_CTRL, 8'h00);
        chk("boot_start", 8'h00, {7'h00, boot_start});
        @(posedge clock_i);
        boot_all <= 1'b1;
        rd(OFS_CTRL, 8'h00);
        prot(0, 8'h40);
        rd(OFS_CTRL, 8'h40);
        chk("boot_all", 8'h00, {7'h00, boot_start});
        prot(0, 8'h00);
        boot_all <= 1'b0;
    endtask

    // fixed priority and a moved pointer
    task automatic s_fixed();
        irq <= 32'h0000_0220;
        pr(8'h05, LVL_LO);
        wr(OFS_PTR, 8'h05);
        pr(8'h09, LVL_LO);
        wr(OFS_PTR, 8'h09);
        pr(8'h05, LVL_LO);
        take(4'h0, 32'h0);
        rd(OFS_PTR, 8'h09);
        rd(OFS_STAT, 8'h01);
        iret();
        rd(OFS_STAT, 8'h00);
        wr(OFS_PTR, 8'h00);
    endtask

    // round robin with a slow core
    task automatic s_rr();
        wr(OFS_CTRL, 8'h01);
        irq <= 32'h0000_0220;
        pr(8'h05, LVL_LO);
        take(4'h3, 32'h0000_0220);
        rd(OFS_PTR, 8'h05);
        iret();
        pr(8'h09, LVL_LO);
        take(4'h0, 32'h0);
        rd(OFS_PTR, 8'h09);
        iret();
        wr(OFS_CTRL, 8'h00);
    endtask

    // nesting level 0, level 1, nmi and unwinding
    task automatic s_nest();
        wr(OFS_HVEC, 8'h09);
        irq <= 32'h0000_0020;
        pr(8'h05, LVL_LO);
        take(4'h1, 32'h0000_0200);
        pr(8'h09, LVL_HI);
        take(4'h0, 32'h0000_0002);
        rd(OFS_STAT, 8'h03);
        pr(VEC_NMI, LVL_NMI);
        take(4'h2, 32'h0000_0220);
        rd(OFS_STAT, 8'h83);
        iret();
        rd(OFS_STAT, 8'h03);
        @(posedge clock_i);
        irq <= 32'h0;
        iret();
        rd(OFS_STAT, 8'h01);
        iret();
        rd(OFS_STAT, 8'h00);
    endtask

    // masking, level 1 off, then the compact table
    task automatic s_modes();
        wr(OFS_HVEC, 8'h00);
        ie <= 1'b0;
        irq <= 32'h0000_0200;
        repeat (3) @(negedge clock_i);
        chk("masked", 8'h00, {7'h00, pres.valid});
        @(posedge clock_i);
        ie <= 1'b1;
        pr(8'h09, LVL_LO);
        take(4'h0, 32'h0);
        iret();
        prot(0, 8'h20);
        rd(OFS_CTRL, 8'h20);
        wr(OFS_HVEC, 8'h09);
        irq <= 32'h0000_0020;
        pr(CVT_LO, LVL_LO);
        take(4'h0, 32'h0000_0200);
        pr(CVT_HI, LVL_HI);
        take(4'h0, 32'h0000_0002);
        pr(CVT_NMI, LVL_NMI);
        take(4'h0, 32'h0);
        repeat (3) iret();
        prot(0, 8'h00);
        irq <= 32'h0000_0020;
        pr(8'h05, LVL_LO);
    endtask

    // reset, then every scenario in turn
    initial
    begin
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        s_regs();
        s_prot();
        s_fixed();
        s_rr();
        s_nest();
        s_modes();
        give_verdict();
    end
endmodule

// *** irq_prio_pkg.sv ***
// constants, types and state layout of the interrupt priority controller
package irq_prio_pkg;

    // vector table size handled by the arbiter
    localparam int NVEC = 32;

    // register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h01;
    localparam logic [7:0] OFS_PTR  = 8'h02;
    localparam logic [7:0] OFS_HVEC = 8'h03;

    // field positions in the control and state registers
    localparam int BIT_PLACE  = 6;
    localparam int BIT_CVT    = 5;
    localparam int BIT_RR     = 0;
    localparam int BIT_NMI_EX = 7;
    localparam int BIT_HI_EX  = 1;
    localparam int BIT_LO_EX  = 0;

    // value of every register after reset
    localparam logic [7:0] RST_REG = 8'h00;

    // unlock window length; the fourth instruction after the key closes it
    localparam logic [2:0] UNLOCK_INSTR = 3'h4;

    // fixed vector numbers
    localparam logic [7:0] VEC_NMI = 8'h01;
    localparam logic [7:0] CVT_NMI = 8'h01;
    localparam logic [7:0] CVT_HI  = 8'h02;
    localparam logic [7:0] CVT_LO  = 8'h03;

    // level of the presented request
    typedef enum logic [1:0] {LVL_NONE, LVL_NMI, LVL_HI, LVL_LO} lvl_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    // indications from the core
    typedef struct packed {
        logic ack;
        logic interrupt_return_instruction;
        logic ie;
    } core_in_t;

    // request presented to the core
    typedef struct packed {
        logic       valid;
        logic [7:0] vector;
        lvl_t       level;
    } core_out_t;

    // whole state of the controller
    typedef struct packed {
        logic       place;
        logic       compact_table_enable;
        logic       rr;
        logic [7:0] ptr;
        logic [7:0] hvec;
        logic       nmi_ex;
        logic       hi_ex;
        logic       lo_ex;
        logic [2:0] unlock;
        core_out_t  out;
        logic [7:0] raw;
        logic [7:0] rdata;
        logic       boot_start;
    } state_t;

endpackage
